// File: include/sds_pkg.sv
// constants shared by the strap decoder and the setpoint controller
package sds_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_PER_US    = 1000 / CLK_PERIOD_NS;
  // strap sense settling time, a least time so rounded up
  localparam int SETTLE_NS     = 2000;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // soft-start durations
  localparam int SS_T0_US      = 500;
  localparam int SS_T1_US      = 770;
  localparam int SS_T2_US      = 1000;
  localparam int SS_T3_US      = 2000;
  // strap positions (msb, lsb) as the decoder reports them
  localparam logic [1:0] POS_SHORT_GND = 2'h0;
  localparam logic [1:0] POS_RES_GND   = 2'h1;
  localparam logic [1:0] POS_RES_SUP   = 2'h2;
  localparam logic [1:0] POS_SHORT_SUP = 2'h3;
  // switching frequency per frequency strap position, in kHz
  localparam logic [11:0] FREQ_KHZ_SHORT_GND = 12'h8ca; // 2250
  localparam logic [11:0] FREQ_KHZ_RES_GND   = 12'h5dc; // 1500
  localparam logic [11:0] FREQ_KHZ_RES_SUP   = 12'hbb8; // 3000
  localparam logic [11:0] FREQ_KHZ_SHORT_SUP = 12'h9c4; // 2500
  // bus target address per second voltage strap position
  localparam logic [6:0] ADDR_SHORT_GND = 7'h45;
  localparam logic [6:0] ADDR_RES_GND   = 7'h44;
  localparam logic [6:0] ADDR_RES_SUP   = 7'h47;
  localparam logic [6:0] ADDR_SHORT_SUP = 7'h46;
  // voltage scale in microvolts
  localparam logic [20:0] BASE_UV     = 21'h061a80; // 400000
  localparam logic [20:0] STEP_UV_R0  = 21'h0004e2; // 1250
  localparam logic [20:0] STEP_UV_R1  = 21'h0009c4; // 2500
  localparam logic [20:0] STEP_UV_R2  = 21'h001388; // 5000
  // range codes and defaults
  localparam logic [1:0] RANGE_FINE   = 2'h0;
  localparam logic [1:0] RANGE_MID    = 2'h1;
  localparam logic [1:0] RANGE_WIDE   = 2'h2;
  // default setpoint codes: low variant 25mV/2.5mV = 10 codes per index
  localparam logic [7:0] DEF_CODE_PER_IDX = 8'h0a;
  localparam logic [7:0] DEF_CODE_HI_BASE = 8'h50; // 400mV offset in 5mV codes
  // slew steps per microsecond, in microvolts
  localparam logic [20:0] SLEW_UV_0   = 21'h002710; // 10 mV/us
  localparam logic [20:0] SLEW_UV_1   = 21'h001388; // 5 mV/us
  localparam logic [20:0] SLEW_UV_2   = 21'h0004e2; // 1.25 mV/us
  localparam logic [20:0] SLEW_UV_3   = 21'h0001f4; // 0.5 mV/us
  localparam logic [1:0]  SLEW_RESET  = 2'h2;
  // register offsets
  localparam logic [2:0] REG_SETPOINT = 3'h0;
  localparam logic [2:0] REG_CTRL_ONE = 3'h1;
  localparam logic [2:0] REG_CTRL_TWO = 3'h2;
  localparam logic [2:0] REG_STATUS   = 3'h3;
  localparam logic [2:0] REG_TGT_LO   = 3'h4;
  localparam logic [2:0] REG_TGT_MID  = 3'h5;
  localparam logic [2:0] REG_TGT_HI   = 3'h6;
  localparam logic [2:0] REG_STRAPS   = 3'h7;
  // field positions in control_reg_one
  localparam int RANGE_LSB = 0;
  localparam int SLEW_LSB  = 2;
  // top-level sequencer states
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_OFF  = 4'h2,
    ST_SOFT = 4'h4,
    ST_RUN  = 4'h8
  } sds_state_type;
  // strap decoder states
  typedef enum logic [3:0] {
    DS_IDLE = 4'h1,
    DS_MSB  = 4'h2,
    DS_LSB  = 4'h4,
    DS_DONE = 4'h8
  } sds_dec_state_type;
endpackage

// File: hw/sds_strap_decoder.sv
// four-level resistor strap decoder for one pin
`timescale 1ns/1ns
`default_nettype none
module sds_strap_decoder (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic       start,
  input  wire logic       pin_level,
  // sense switches, high closes the switch
  output logic            sw_a,
  output logic            sw_b,
  // result
  output logic [1:0]      code,
  output logic            done
);
  sds_pkg::sds_dec_state_type state;
  logic [7:0]                 settle;
  logic                       settled;

  // the buffer needs time after every switch change before a sample is trusted
  assign settled = (settle == 8'(sds_pkg::SETTLE_CYC - 1));

  // sequence: open switches, sample msb, close one switch, sample lsb
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state  <= sds_pkg::DS_IDLE;
      settle <= 8'h00;
      sw_a   <= 1'b0;
      sw_b   <= 1'b0;
      code   <= 2'h0;
      done   <= 1'b0;
    end else begin
      case (state)
        sds_pkg::DS_IDLE: begin
          if (start) begin
            state  <= sds_pkg::DS_MSB;
            settle <= 8'h00;
            sw_a   <= 1'b0;
            sw_b   <= 1'b0;
            done   <= 1'b0;
          end
        end
        sds_pkg::DS_MSB: begin
          if (settled) begin
            // R2: msb open sample
            code[1] <= pin_level;
            // R3: msb zero closes a
            sw_a    <= !pin_level;
            // R4: msb one closes b
            sw_b    <= pin_level;
            settle  <= 8'h00;
            state   <= sds_pkg::DS_LSB;
          end else begin
            settle <= settle + 8'h01;
          end
        end
        sds_pkg::DS_LSB: begin
          if (settled) begin
            // R3: lsb follows level
            code[0] <= pin_level;
            sw_a    <= 1'b0;
            sw_b    <= 1'b0;
            done    <= 1'b1;
            state   <= sds_pkg::DS_DONE;
          end else begin
            settle <= settle + 8'h01;
          end
        end
        sds_pkg::DS_DONE: begin
          // R15: result held
          state <= sds_pkg::DS_DONE;
        end
        default: begin
          state <= sds_pkg::DS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hw/sds_setpoint_ctrl.sv
// strap decoding at initialization and output voltage setpoint control
//
// Overview of operation
// R1: the frequency strap is decoded once at initialization into 1.5, 2.25, 2.5 or 3 MHz.
// R2: the strap msb is sampled with both sense switches open, high giving one.
// R3: with msb zero the first sense switch closes and a high level gives lsb one.
// R4: with msb one the second sense switch closes and a low level gives lsb zero.
// R5: range 0, 1 and 2 or 3 select 1.25, 2.5 and 5 mV steps.
// R6: after initialization the range defaults to 2.5 mV steps on the low variant, 5 mV otherwise.
// R7: a written range becomes active only at the next setpoint write.
// R8: the target is 0.4 V plus the setpoint code times the active step.
// R9: both voltage straps are decoded at initialization to load the default setpoint and address.
// R10: the bus address follows only the second voltage strap, 0x45, 0x44, 0x47, 0x46.
// R11: the low variant default is 400 mV plus 25 mV times the sixteen-position strap index.
// R12: the high variant default is 800 mV plus 50 mV times the same index.
// R13: setpoint, range and ramp time written during soft start wait until it ends.
// R14: setpoint changes in operation slew at the rate of the slew field, default code 2.
// R15: decoded strap results stay latched until the next initialization.
`timescale 1ns/1ns
`default_nettype none
module sds_setpoint_ctrl #(
  parameter bit LOW_VOLT_VARIANT = 1'b0,
  parameter int SS_CYC_0         = sds_pkg::SS_T0_US * sds_pkg::CLK_PER_US,
  parameter int SS_CYC_1         = sds_pkg::SS_T1_US * sds_pkg::CLK_PER_US,
  parameter int SS_CYC_2         = sds_pkg::SS_T2_US * sds_pkg::CLK_PER_US,
  parameter int SS_CYC_3         = sds_pkg::SS_T3_US * sds_pkg::CLK_PER_US
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // strap pins and their sense switches, index 0 freq, 1 volt a, 2 volt b
  input  wire logic        FREQ_STRAP_PIN,
  input  wire logic        VOLT_STRAP_PIN_A,
  input  wire logic        VOLT_STRAP_PIN_B,
  output logic [2:0]       SENSE_SWITCH_A,
  output logic [2:0]       SENSE_SWITCH_B,
  // enable pin and its initialization pull-down
  input  wire logic        ENABLE,
  output logic             EN_PULL_LOW,
  // register port
  input  wire logic [2:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [7:0]       RDATA,
  // decoded configuration and voltages
  output logic [11:0]      FREQ_KHZ,
  output logic [6:0]       BUS_ADDR,
  output logic [20:0]      TARGET_UV,
  output logic [20:0]      VOUT_UV,
  output logic             SOFT_START_ACTIVE
);
  localparam logic [1:0] RANGE_DEFAULT = LOW_VOLT_VARIANT ? sds_pkg::RANGE_MID : sds_pkg::RANGE_WIDE;
  localparam logic [1:0] SS_DEFAULT    = LOW_VOLT_VARIANT ? 2'h1 : 2'h2;

  sds_pkg::sds_state_type state;
  logic [2:0]             pins;
  logic [1:0]             pos [3];
  logic [2:0]             dec_done;
  logic                   dec_start;
  logic                   init_started;
  // software-visible registers, plus the active range that is not read back
  logic [7:0]             setpoint_code;
  logic [1:0]             range_select;
  logic [1:0]             slew_select;
  logic [1:0]             soft_ramp_time;
  logic [1:0]             active_range;
  // values the converter actually uses
  logic [7:0]             run_code;
  logic [1:0]             run_range;
  logic [14:0]            ss_count;
  logic [14:0]            ss_limit;
  logic [3:0]             us_div;
  logic                   us_tick;
  logic [20:0]            next_target;
  logic [20:0]            slew_step;
  logic [3:0]             strap_index;
  logic                   wr_ok;

  assign pins = {VOLT_STRAP_PIN_B, VOLT_STRAP_PIN_A, FREQ_STRAP_PIN};

  // one identical decoder per strap pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_dec
      sds_strap_decoder u_dec (
        .clk       (CLK),
        .rstn      (RSTN),
        .start     (dec_start),
        .pin_level (pins[gi]),
        .sw_a      (SENSE_SWITCH_A[gi]),
        .sw_b      (SENSE_SWITCH_B[gi]),
        .code      (pos[gi]),
        .done      (dec_done[gi])
      );
    end
  endgenerate

  // kick the decoders once after reset release
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      init_started <= 1'b0;
    end else begin
      init_started <= 1'b1;
    end
  end
  assign dec_start = !init_started;

  // sequencer: init, off, soft start, run
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= sds_pkg::ST_INIT;
    end else begin
      case (state)
        sds_pkg::ST_INIT: begin
          if (&dec_done) begin
            state <= sds_pkg::ST_OFF;
          end
        end
        sds_pkg::ST_OFF: begin
          if (ENABLE) begin
            state <= sds_pkg::ST_SOFT;
          end
        end
        sds_pkg::ST_SOFT: begin
          if (!ENABLE) begin
            state <= sds_pkg::ST_OFF;
          end else if (ss_count == ss_limit) begin
            state <= sds_pkg::ST_RUN;
          end
        end
        sds_pkg::ST_RUN: begin
          if (!ENABLE) begin
            state <= sds_pkg::ST_OFF;
          end
        end
        default: begin
          state <= sds_pkg::ST_INIT;
        end
      endcase
    end
  end

  // the enable pin is held low until straps are read
  assign EN_PULL_LOW       = (state == sds_pkg::ST_INIT);
  assign SOFT_START_ACTIVE = (state == sds_pkg::ST_SOFT);

  // R9: index from both voltage straps
  assign strap_index = {pos[1], pos[2]};

  // R1: frequency latched from strap
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      FREQ_KHZ <= 12'h000;
      BUS_ADDR <= 7'h00;
    end else if (state == sds_pkg::ST_INIT && (&dec_done)) begin
      // R15: captured only here
      case (pos[0])
        sds_pkg::POS_SHORT_GND: FREQ_KHZ <= sds_pkg::FREQ_KHZ_SHORT_GND;
        sds_pkg::POS_RES_GND:   FREQ_KHZ <= sds_pkg::FREQ_KHZ_RES_GND;
        sds_pkg::POS_RES_SUP:   FREQ_KHZ <= sds_pkg::FREQ_KHZ_RES_SUP;
        default:                FREQ_KHZ <= sds_pkg::FREQ_KHZ_SHORT_SUP;
      endcase
      // R10: address from strap b
      case (pos[2])
        sds_pkg::POS_SHORT_GND: BUS_ADDR <= sds_pkg::ADDR_SHORT_GND;
        sds_pkg::POS_RES_GND:   BUS_ADDR <= sds_pkg::ADDR_RES_GND;
        sds_pkg::POS_RES_SUP:   BUS_ADDR <= sds_pkg::ADDR_RES_SUP;
        default:                BUS_ADDR <= sds_pkg::ADDR_SHORT_SUP;
      endcase
    end
  end

  // register writes are taken only once initialization is over; reads answer at any time
  assign wr_ok = WR && (state != sds_pkg::ST_INIT);

  // software registers; setpoint and range defaults loaded when the straps are in, slew and ramp time defaults at reset only
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      setpoint_code  <= 8'h00;
      range_select   <= RANGE_DEFAULT;
      active_range   <= RANGE_DEFAULT;
      slew_select    <= sds_pkg::SLEW_RESET;
      soft_ramp_time <= SS_DEFAULT;
    end else if (state == sds_pkg::ST_INIT) begin
      if (&dec_done) begin
        // R6: range default per variant
        range_select <= RANGE_DEFAULT;
        active_range <= RANGE_DEFAULT;
        // R11: low variant default
        // R12: high variant default
        if (LOW_VOLT_VARIANT) begin
          setpoint_code <= 8'(strap_index * sds_pkg::DEF_CODE_PER_IDX);
        end else begin
          setpoint_code <= sds_pkg::DEF_CODE_HI_BASE + 8'(strap_index * sds_pkg::DEF_CODE_PER_IDX);
        end
      end
    end else if (wr_ok) begin
      if (ADDR == sds_pkg::REG_SETPOINT) begin
        setpoint_code <= WDATA;
        // R7: range applied on setpoint write
        active_range  <= range_select;
      end else if (ADDR == sds_pkg::REG_CTRL_ONE) begin
        range_select <= WDATA[sds_pkg::RANGE_LSB +: 2];
        // R14: slew field written
        slew_select  <= WDATA[sds_pkg::SLEW_LSB +: 2];
      end else if (ADDR == sds_pkg::REG_CTRL_TWO) begin
        soft_ramp_time <= WDATA[1:0];
      end
    end
  end

  // R13: values frozen while soft start runs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      run_code  <= 8'h00;
      run_range <= RANGE_DEFAULT;
      ss_limit  <= 15'h0000;
    end else if (state == sds_pkg::ST_OFF) begin
      // whatever was written while disabled is used at the next enable, a new range only once a setpoint write follows
      run_code  <= setpoint_code;
      run_range <= active_range;
      case (soft_ramp_time)
        2'h0:    ss_limit <= 15'(SS_CYC_0 - 1);
        2'h1:    ss_limit <= 15'(SS_CYC_1 - 1);
        2'h2:    ss_limit <= 15'(SS_CYC_2 - 1);
        default: ss_limit <= 15'(SS_CYC_3 - 1);
      endcase
    end else if (state == sds_pkg::ST_RUN) begin
      run_code  <= setpoint_code;
      run_range <= active_range;
    end
  end

  // soft-start timer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ss_count <= 15'h0000;
    end else if (state == sds_pkg::ST_SOFT) begin
      ss_count <= ss_count + 15'h0001;
    end else begin
      ss_count <= 15'h0000;
    end
  end

  // R5: step size by range
  // R8: target from code and step
  always_comb begin
    case (run_range)
      sds_pkg::RANGE_FINE: next_target = sds_pkg::BASE_UV + 21'(run_code) * sds_pkg::STEP_UV_R0;
      sds_pkg::RANGE_MID:  next_target = sds_pkg::BASE_UV + 21'(run_code) * sds_pkg::STEP_UV_R1;
      default:             next_target = sds_pkg::BASE_UV + 21'(run_code) * sds_pkg::STEP_UV_R2;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      TARGET_UV <= 21'h000000;
    end else begin
      TARGET_UV <= next_target;
    end
  end

  // microsecond enable for the slew steps
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      us_div <= 4'h0;
    end else if (us_tick) begin
      us_div <= 4'h0;
    end else begin
      us_div <= us_div + 4'h1;
    end
  end
  assign us_tick = (us_div == 4'(sds_pkg::CLK_PER_US - 1));

  // R14: step per microsecond
  always_comb begin
    case (slew_select)
      2'h0:    slew_step = sds_pkg::SLEW_UV_0;
      2'h1:    slew_step = sds_pkg::SLEW_UV_1;
      2'h2:    slew_step = sds_pkg::SLEW_UV_2;
      default: slew_step = sds_pkg::SLEW_UV_3;
    endcase
  end

  // output model: zero when off, the frozen target in soft start, slewed in run
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      VOUT_UV <= 21'h000000;
    end else if (state == sds_pkg::ST_SOFT) begin
      // taken from the frozen code directly so a write in the last off cycle cannot leave a one-cycle step
      VOUT_UV <= next_target;
    end else if (state == sds_pkg::ST_RUN) begin
      // R14: slew toward target
      if (us_tick && VOUT_UV < TARGET_UV) begin
        VOUT_UV <= (TARGET_UV - VOUT_UV > slew_step) ? VOUT_UV + slew_step : TARGET_UV;
      end else if (us_tick && VOUT_UV > TARGET_UV) begin
        VOUT_UV <= (VOUT_UV - TARGET_UV > slew_step) ? VOUT_UV - slew_step : TARGET_UV;
      end
    end else begin
      VOUT_UV <= 21'h000000;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (!RD) begin
      RDATA <= 8'h00;
    end else if (ADDR == sds_pkg::REG_SETPOINT) begin
      RDATA <= setpoint_code;
    end else if (ADDR == sds_pkg::REG_CTRL_ONE) begin
      RDATA <= {4'h0, slew_select, range_select};
    end else if (ADDR == sds_pkg::REG_CTRL_TWO) begin
      RDATA <= {6'h00, soft_ramp_time};
    end else if (ADDR == sds_pkg::REG_STATUS) begin
      RDATA <= {3'h0, (VOUT_UV != TARGET_UV), state};
    end else if (ADDR == sds_pkg::REG_TGT_LO) begin
      RDATA <= TARGET_UV[7:0];
    end else if (ADDR == sds_pkg::REG_TGT_MID) begin
      RDATA <= TARGET_UV[15:8];
    end else if (ADDR == sds_pkg::REG_TGT_HI) begin
      RDATA <= {3'h0, TARGET_UV[20:16]};
    end else begin
      RDATA <= {2'h0, pos[0], pos[1], pos[2]};
    end
  end
endmodule
`default_nettype wire

// File: tb/sds_strap_model.sv
// behavioural four-level resistor strap seen through the sense switches
`timescale 1ns/1ns
`default_nettype none
module sds_strap_model (
  // strap position: 0 short-gnd, 1 6.2k-gnd, 2 47k-sup, 3 short-sup
  input  wire logic [1:0] pos,
  // sense switches, high closes the switch
  input  wire logic       sw_a,
  input  wire logic       sw_b,
  // level at the input buffer
  output logic            level
);
  // open switches show the strap side, a closed switch overpowers a resistor only
  always_comb begin
    case (pos)
      2'h0: level = 1'b0;
      2'h1: level = sw_a;
      2'h2: level = ~sw_b;
      default: level = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// File: tb/sds_setpoint_ctrl_assertions.sv
// concurrent checks on the ports of the setpoint controller
`timescale 1ns/1ns
`default_nettype none
module sds_setpoint_ctrl_assertions (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // inputs of interest
  input wire logic        ENABLE,
  input wire logic        RD,
  // outputs watched
  input wire logic [2:0]  SENSE_SWITCH_A,
  input wire logic [2:0]  SENSE_SWITCH_B,
  input wire logic        EN_PULL_LOW,
  input wire logic [7:0]  RDATA,
  input wire logic [11:0] FREQ_KHZ,
  input wire logic [6:0]  BUS_ADDR,
  input wire logic [20:0] TARGET_UV,
  input wire logic [20:0] VOUT_UV,
  input wire logic        SOFT_START_ACTIVE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // never both switches on one pin
  a_one_switch: assert property (!(|(SENSE_SWITCH_A & SENSE_SWITCH_B)))
    else $error("both sense switches closed");
  a_switch_in_init: assert property ((|SENSE_SWITCH_A) || (|SENSE_SWITCH_B) |-> EN_PULL_LOW)
    else $error("sense switch closed outside init");
  a_init_bounded: assert property (EN_PULL_LOW |-> ##[1:300] !EN_PULL_LOW)
    else $error("initialization too long");
  a_freq_legal: assert property (!EN_PULL_LOW |-> FREQ_KHZ inside {12'h5dc, 12'h8ca, 12'h9c4, 12'hbb8})
    else $error("illegal switching frequency");
  // address set is 0x44 to 0x47
  a_addr_legal: assert property (!EN_PULL_LOW |-> BUS_ADDR inside {7'h44, 7'h45, 7'h46, 7'h47})
    else $error("illegal bus address");
  // decoded straps hold once init is over
  a_straps_held: assert property ((!EN_PULL_LOW ##1 !EN_PULL_LOW) |-> $stable(FREQ_KHZ) && $stable(BUS_ADDR))
    else $error("strap result changed after init");
  // target stays within 0.4 V and 1.675 V while ramping
  a_target_span: assert property (SOFT_START_ACTIVE |-> TARGET_UV >= 21'h061a80 && TARGET_UV <= 21'h198ef8)
    else $error("target out of span");
  // target and output frozen during soft start
  a_soft_frozen: assert property (SOFT_START_ACTIVE [*3] |-> $stable(TARGET_UV) && $stable(VOUT_UV))
    else $error("value moved during soft start");
  // dropping enable stops the ramp next cycle
  a_soft_exit: assert property (SOFT_START_ACTIVE && !ENABLE |=> !SOFT_START_ACTIVE)
    else $error("soft start kept without enable");
  a_vout_off: assert property (!ENABLE [*3] |-> VOUT_UV == 21'h000000)
    else $error("output nonzero while disabled");
  // read data idle outside read answers
  a_read_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside answer cycle");
endmodule
bind sds_setpoint_ctrl sds_setpoint_ctrl_assertions u_chk (
  .CLK(CLK), .RSTN(RSTN), .ENABLE(ENABLE), .RD(RD), .SENSE_SWITCH_A(SENSE_SWITCH_A),
  .SENSE_SWITCH_B(SENSE_SWITCH_B), .EN_PULL_LOW(EN_PULL_LOW), .RDATA(RDATA), .FREQ_KHZ(FREQ_KHZ),
  .BUS_ADDR(BUS_ADDR), .TARGET_UV(TARGET_UV), .VOUT_UV(VOUT_UV), .SOFT_START_ACTIVE(SOFT_START_ACTIVE)
);
`default_nettype wire

// File: tb/sds_setpoint_ctrl_bench.sv
// self-checking bench for the strap decode and setpoint controller
`timescale 1ns/1ns
`default_nettype none
module sds_setpoint_ctrl_bench;
  localparam logic [11:0] freq_tab [4] = '{12'h8ca, 12'h5dc, 12'hbb8, 12'h9c4};
  localparam logic [6:0]  addr_tab [4] = '{7'h45, 7'h44, 7'h47, 7'h46};
  localparam logic [20:0] step_tab [4] = '{sds_pkg::STEP_UV_R0, sds_pkg::STEP_UV_R1,
                                           sds_pkg::STEP_UV_R2, sds_pkg::STEP_UV_R2};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        enable = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [1:0]  pos_f = 2'h0;
  logic [1:0]  pos_a = 2'h0;
  logic [1:0]  pos_b = 2'h0;
  logic        pin_f;
  logic        pin_a;
  logic        pin_b;
  logic [2:0]  sw_a;
  logic [2:0]  sw_b;
  logic        en_pull_low;
  logic [7:0]  rdata;
  logic [11:0] freq_khz;
  logic [6:0]  bus_addr;
  logic [20:0] target_uv;
  logic [20:0] vout_uv;
  logic        soft_active;
  logic [7:0]  rdata_low;
  logic [20:0] target_low;
  logic [20:0] exp_uv;
  int          n_mismatch = 0;
  int          checks = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  // short soft-start counts keep each ramp to tens of cycles
  sds_setpoint_ctrl #(.LOW_VOLT_VARIANT(1'b0), .SS_CYC_0(20), .SS_CYC_1(30), .SS_CYC_2(40), .SS_CYC_3(50)) DUT (
    .CLK(clk), .RSTN(rstn), .FREQ_STRAP_PIN(pin_f), .VOLT_STRAP_PIN_A(pin_a), .VOLT_STRAP_PIN_B(pin_b),
    .SENSE_SWITCH_A(sw_a), .SENSE_SWITCH_B(sw_b), .ENABLE(enable), .EN_PULL_LOW(en_pull_low),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .FREQ_KHZ(freq_khz),
    .BUS_ADDR(bus_addr), .TARGET_UV(target_uv), .VOUT_UV(vout_uv), .SOFT_START_ACTIVE(soft_active)
  );

  // low-voltage variant on the same straps and bus; its decoders run in lockstep with the first
  sds_setpoint_ctrl #(.LOW_VOLT_VARIANT(1'b1), .SS_CYC_0(20), .SS_CYC_1(30), .SS_CYC_2(40), .SS_CYC_3(50)) DUT_LOW (
    .CLK(clk), .RSTN(rstn), .FREQ_STRAP_PIN(pin_f), .VOLT_STRAP_PIN_A(pin_a), .VOLT_STRAP_PIN_B(pin_b),
    .SENSE_SWITCH_A(), .SENSE_SWITCH_B(), .ENABLE(enable), .EN_PULL_LOW(), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata_low), .FREQ_KHZ(), .BUS_ADDR(), .TARGET_UV(target_low), .VOUT_UV(),
    .SOFT_START_ACTIVE()
  );

  // one strap per pin
  sds_strap_model u_fstrap (.pos(pos_f), .sw_a(sw_a[0]), .sw_b(sw_b[0]), .level(pin_f));
  sds_strap_model u_astrap (.pos(pos_a), .sw_a(sw_a[1]), .sw_b(sw_b[1]), .level(pin_a));
  sds_strap_model u_bstrap (.pos(pos_b), .sw_a(sw_a[2]), .sw_b(sw_b[2]), .level(pin_b));

  // compare and count
  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, 21'(exp), 21'(rdata));
  endtask

  // settle a fixed count, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait on the soft-start flag
  task automatic wait_soft(input logic lvl);
    for (int k = 0; k < 200 && soft_active !== lvl; k++) @(posedge clk);
    #1;
    check("soft start flag", 21'(lvl), 21'(soft_active));
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    // every strap position, index 0, 5, 10 and 15
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pos_f <= 2'(i);
      pos_a <= 2'(i);
      pos_b <= 2'(i);
      rstn <= 1'b0;
      enable <= 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      for (int k = 0; k < 400 && en_pull_low !== 1'b0; k++) @(posedge clk);
      #1;
      check("init done", 21'h0, 21'(en_pull_low));
      check("frequency", 21'(freq_tab[i]), 21'(freq_khz));
      check("bus address", 21'(addr_tab[i]), 21'(bus_addr));
      reg_rd("strap positions", sds_pkg::REG_STRAPS, {2'h0, 2'(i), 2'(i), 2'(i)});
      reg_rd("default code", sds_pkg::REG_SETPOINT, 8'(8'h50 + 8'h32 * i));
      check("low variant default code", 21'(8'h32 * i), 21'(rdata_low));
      reg_rd("range and slew", sds_pkg::REG_CTRL_ONE, 8'h0a);
      check("low variant range and slew", 21'h09, 21'(rdata_low));
      @(posedge clk);
      pos_f <= 2'(3 - i);
      enable <= 1'b1;
      wait_soft(1'b1);
      wait_soft(1'b0);
      settle(3);
      exp_uv = 21'(21'h0c3500 + 21'h00c350 * 5 * i);
      check("default target", exp_uv, target_uv);
      check("output at target", exp_uv, vout_uv);
      check("low variant target", 21'(21'h061a80 + 21'h01e848 * i), target_low);
      check("latched frequency", 21'(freq_tab[i]), 21'(freq_khz));
      $display("test strap position %0d done", i);
    end
    // a range takes hold only at the next setpoint write
    for (int r = 0; r < 4; r++) begin
      reg_wr(sds_pkg::REG_CTRL_ONE, 8'(r));
      settle(4);
      check("target before setpoint write", exp_uv, target_uv);
      reg_rd("range field", sds_pkg::REG_CTRL_ONE, 8'(r));
      reg_wr(sds_pkg::REG_SETPOINT, 8'hff);
      settle(4);
      exp_uv = sds_pkg::BASE_UV + 21'h0000ff * step_tab[r];
      check("target after setpoint write", exp_uv, target_uv);
    end
    reg_wr(sds_pkg::REG_STRAPS, 8'h00);
    reg_rd("read-only straps", sds_pkg::REG_STRAPS, 8'h3f);
    $display("test range switching done");
    // a setpoint written in soft start waits, then slews
    @(posedge clk);
    enable <= 1'b0;
    settle(5);
    @(posedge clk);
    enable <= 1'b1;
    wait_soft(1'b1);
    reg_wr(sds_pkg::REG_SETPOINT, 8'h00);
    settle(4);
    check("target frozen in soft start", exp_uv, target_uv);
    wait_soft(1'b0);
    settle(4);
    check("target after soft start", sds_pkg::BASE_UV, target_uv);
    check("output still slewing", 21'h1, 21'(vout_uv > target_uv));
    // a full-scale step at the fastest slew lasts over a thousand cycles, so these reads see it moving
    reg_rd("status while slewing", sds_pkg::REG_STATUS, 8'h18);
    reg_rd("target low byte", sds_pkg::REG_TGT_LO, 8'h80);
    reg_rd("target mid byte", sds_pkg::REG_TGT_MID, 8'h1a);
    reg_rd("target high byte", sds_pkg::REG_TGT_HI, 8'h06);
    reg_rd("ramp time default", sds_pkg::REG_CTRL_TWO, 8'h02);
    $display("test soft start hold done");
    close_out();
  end

  // watchdog sized far beyond four init and ramp rounds
  initial begin
    #(20000 * 100);
    n_mismatch++;
    $display("Error watchdog expected finish seen timeout");
    close_out();
  end
endmodule
`default_nettype wire
